// ===== common/charge_pkg.sv
// shared constants and types for the charge-cycle supervisor
package charge_pkg;
	// register offsets
	localparam logic [7:0] ADDR_BAL_TIMING = 8'h28;
	localparam logic [7:0] ADDR_BAL_THRESH = 8'h29;
	localparam logic [7:0] ADDR_BAL_CTRL = 8'h2a;
	// reset values and writable bits
	localparam logic [7:0] RST_BAL_TIMING = 8'h2a;
	localparam logic [7:0] RST_BAL_THRESH = 8'hf4;
	localparam logic [7:0] RST_BAL_CTRL = 8'hc0;
	localparam logic [7:0] CTRL_WR_MASK = 8'hc0;
	// field positions
	localparam int PAUSE_BIT = 7;
	localparam int AUTO_EN_BIT = 6;
	localparam int PREQ_TH_MSB = 7;
	localparam int PREQ_TH_LSB = 4;
	localparam int START_MSB = 3;
	localparam int START_LSB = 0;
	localparam int EXIT_MSB = 7;
	localparam int EXIT_LSB = 5;
	localparam int PREQ_INT_BIT = 4;
	localparam int ACT_INT_MSB = 3;
	localparam int ACT_INT_LSB = 2;
	localparam int SETTLE_BIT = 1;
	localparam logic [3:0] PREQ_DISABLED = 4'hf;
	// charge phase codes
	typedef logic [2:0] phase_t;
	localparam phase_t PH_IDLE = 3'h0;
	localparam phase_t PH_TRICKLE = 3'h1;
	localparam phase_t PH_PRE = 3'h2;
	localparam phase_t PH_FAST = 3'h3;
	localparam phase_t PH_TAPER = 3'h4;
	localparam phase_t PH_TOPOFF = 3'h5;
	localparam phase_t PH_DONE = 3'h6;
	// zone selections
	localparam logic [1:0] ZONE_SUSPEND = 2'h3;
	localparam logic [1:0] PCT_100 = 2'h0;
	localparam logic [1:0] PCT_40 = 2'h1;
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int INT_PULSE_NS = 256000;
	localparam int MS_PER_MIN = 60000;
	localparam int MS_PER_HOUR = 3600000;
	localparam int SETTLE_LONG_MS = 1000;
	localparam int SETTLE_SHORT_MS = 500;
	localparam int PREQ_INTERVAL_0_MS = 2 * MS_PER_MIN;
	localparam int PREQ_INTERVAL_1_MS = 4 * MS_PER_MIN;
	localparam int ACT_INTERVAL_UNIT_MS = MS_PER_MIN / 2;
	localparam int PRECHARGE_HOURS = 2;
	localparam int TIMER_W = 28;
	localparam int MEAS_W = 20;
	typedef enum logic [3:0] {BAL_OFF = 4'b0001, BAL_PREQ = 4'b0010, BAL_QUAL = 4'b0100,
		BAL_ACTIVE = 4'b1000} bal_state_e;
	typedef enum logic [2:0] {MEAS_WAIT = 3'b001, MEAS_SETTLE = 3'b010, MEAS_SAMPLE = 3'b100} meas_state_e;
	// analogue status, cell_diff in 20 mV steps
	typedef struct packed {
		logic charge_enable;
		logic vbat_short;
		logic vbat_low;
		logic above_rechg;
		logic below_term;
		logic cv_mode;
		logic in_ireg;
		logic in_vreg;
		logic in_treg;
		logic fault;
		logic supplement;
		logic ts_in_range;
		logic ts_warm;
		logic ts_cool;
		logic upper_cell_cv;
		logic lower_cell_cv;
		logic upper_cell_higher;
		logic [7:0] cell_diff;
	} charge_sense_s;
	typedef struct packed {
		logic term_enable;
		logic timer_enable;
		logic half_rate_enable;
		logic charge_irq_mask;
		logic [1:0] warm_voltage_select;
		logic warm_current_select;
		logic [1:0] cool_current_select;
		logic [4:0] safety_timer_duration;
		logic [7:0] topoff_minutes;
	} zone_cfg_s;
	typedef struct packed {
		logic charge_run;
		logic [1:0] voltage_sel;
		logic [1:0] current_pct;
	} charge_ctl_s;
endpackage : charge_pkg

// ===== design/charge_cycle_supervisor.sv
// charge-cycle supervisor: balancing, termination, top-off, zones, safety timers
//
// Notes on behaviour
// RL1 - balance and cell regulation status stay live in automatic and manual modes
// RL2 - control register holds auto enable bit 6, pause-for-measure bit 7, both reset 1
// RL3 - threshold register upper nibble enters qualification; 1111 skips pre-qualification
// RL4 - threshold register lower nibble starts active discharge; reset 0100 is 80 mV
// RL5 - timing register bits 7:5 give exit offset; reset 001 is 40 mV
// RL6 - bit 4 pre-qualification interval, bits 3:2 active interval, both default 2 minutes
// RL7 - pause charge, wait selected settle delay, then sample cell voltages
// RL8 - sequencer steps by measured difference, leaves active below start minus offset
// RL9 - terminate when above recharge level and current below termination level
// RL10 - on termination release status pin, phase 110, interrupt pulse
// RL11 - termination held off in regulation; termination enable low blocks it
// RL12 - optional top-off runs with phase 101, expiry gives 110 and pulse
// RL13 - top-off clears on charge enable, termination rise, register reset disables it
// RL14 - top-off length latched at termination, later writes wait for recharge
// RL15 - pulses on top-off entry and expiry; charge mask suppresses charge pulses
// RL16 - charge only while thermistor inside outer limits, else suspended
// RL17 - warm zone picks voltage target or suspend, and 100 or 40 percent current
// RL18 - cool zone picks 100, 40, 20 percent current or suspend
// RL19 - warm or cool zone disables termination
// RL20 - safety timer expiry sets fault bit and pulses; enable low disables it
// RL21 - half rate in regulation or active balancing; enable change keeps count
// RL22 - timer pauses on faults and supplement, clears on restart, recharge or low-voltage threshold crossing
// RL23 - fixed two-hour pre-charge timer below low-voltage threshold, same rules
// RL24 - phase codes 000 to 110 from idle through termination done
// RL25 - each interrupt is a 256 us active-low pulse
`timescale 1ns/1ps
module charge_cycle_supervisor import charge_pkg::*; #(
	parameter int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS,
	parameter int INT_PULSE_CYCLES = INT_PULSE_NS / CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_reset,
	output logic [7:0] reg_rdata,
	// configuration bits
	input wire zone_cfg_s cfg,
	input wire logic manual_balance_on,
	// analogue status
	input wire charge_sense_s sense_raw,
	// charge control
	output charge_ctl_s ctl,
	output logic charge_pause,
	output logic discharge_upper,
	output logic discharge_lower,
	// status
	output logic [2:0] charge_phase,
	output logic timer_fault_status,
	output logic balance_active_status,
	output logic upper_cell_regulation_status,
	output logic lower_cell_regulation_status,
	// pins
	output logic stat_oe,
	output logic int_n
);
	localparam logic [TIMER_W-1:0] HALF_PER_HOUR = TIMER_W'(2 * MS_PER_HOUR);
	localparam logic [TIMER_W-1:0] HALF_PER_MIN = TIMER_W'(2 * MS_PER_MIN);
	localparam logic [TIMER_W-1:0] PRE_LIMIT = TIMER_W'(PRECHARGE_HOURS) * HALF_PER_HOUR;
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
	localparam logic [15:0] INT_LOAD = 16'(INT_PULSE_CYCLES - 1);

	charge_sense_s sense_meta, sense;
	logic [7:0] bal_timing, bal_thresh, bal_ctrl;
	logic [31:0] tick_div;
	logic tick;
	bal_state_e bal_state;
	meas_state_e meas_state;
	logic [MEAS_W-1:0] meas_cnt;
	logic auto_en, pause_en;
	logic [3:0] prequal_th, start_th;
	logic [2:0] exit_off;
	logic zone_suspend, charging_allowed, term_allowed, term_event;
	logic term_done, term_done_prev, topoff_active;
	logic [TIMER_W-1:0] topoff_len, safety_limit;
	logic charge_en_prev, vbat_low_prev, en_rise, recharge, lowv_change;
	logic timer_clear, timer_suspend, in_charge, half;
	logic fast_exp, pre_exp, topoff_exp;
	phase_t next_phase;
	logic fire;
	logic [15:0] int_cnt;
	logic [15:0] low_run;

	// active interval selection, reused for qualification and active; code 10 is two minutes
	function automatic logic [MEAS_W-1:0] active_interval(input logic [1:0] code);
		return MEAS_W'(ACT_INTERVAL_UNIT_MS) << code; // RL6
	endfunction : active_interval

	function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] t, input logic [7:0] h,
		input logic [7:0] c);
		case (addr)
			ADDR_BAL_TIMING: return t;
			ADDR_BAL_THRESH: return h;
			ADDR_BAL_CTRL: return c;
			default: return 8'h00;
		endcase
	endfunction : read_mux

	// two-stage capture of the analogue status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sense_meta <= '0;
			sense <= '0;
		end else begin
			sense_meta <= sense_raw;
			sense <= sense_meta;
		end
	end

	// balancing registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bal_timing <= RST_BAL_TIMING;
			bal_thresh <= RST_BAL_THRESH;
			bal_ctrl <= RST_BAL_CTRL; // RL2
		end else if (reg_reset) begin
			bal_timing <= RST_BAL_TIMING;
			bal_thresh <= RST_BAL_THRESH;
			bal_ctrl <= RST_BAL_CTRL;
		end else if (reg_we) begin
			case (reg_addr)
				ADDR_BAL_TIMING: bal_timing <= reg_wdata;
				ADDR_BAL_THRESH: bal_thresh <= reg_wdata;
				ADDR_BAL_CTRL: bal_ctrl <= reg_wdata & CTRL_WR_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= read_mux(reg_addr, bal_timing, bal_thresh, bal_ctrl);
		end
	end

	assign auto_en = bal_ctrl[AUTO_EN_BIT];
	assign pause_en = bal_ctrl[PAUSE_BIT];
	assign prequal_th = bal_thresh[PREQ_TH_MSB:PREQ_TH_LSB]; // RL3
	assign start_th = bal_thresh[START_MSB:START_LSB]; // RL4
	assign exit_off = bal_timing[EXIT_MSB:EXIT_LSB]; // RL5

	// millisecond tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_div <= 32'h0;
		end else if (tick) begin
			tick_div <= 32'h0;
		end else begin
			tick_div <= tick_div + 32'h1;
		end
	end
	assign tick = tick_div == TICK_LAST;

	// measurement pacing: interval, optional pause with settle, sample
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meas_state <= MEAS_WAIT;
			meas_cnt <= '0;
		end else if (!auto_en || bal_state == BAL_OFF) begin
			meas_state <= MEAS_WAIT;
			meas_cnt <= '0;
		end else begin
			case (meas_state)
				MEAS_WAIT: begin
					if (meas_cnt >= (bal_state == BAL_PREQ ? (bal_timing[PREQ_INT_BIT] ? MEAS_W'(PREQ_INTERVAL_1_MS)
						: MEAS_W'(PREQ_INTERVAL_0_MS)) : active_interval(bal_timing[ACT_INT_MSB:ACT_INT_LSB]))) begin // RL6
						meas_state <= pause_en ? MEAS_SETTLE : MEAS_SAMPLE;
						meas_cnt <= '0;
					end else if (tick) begin
						meas_cnt <= meas_cnt + 1'b1;
					end
				end
				MEAS_SETTLE: begin
					if (meas_cnt >= (bal_timing[SETTLE_BIT] ? MEAS_W'(SETTLE_LONG_MS) : MEAS_W'(SETTLE_SHORT_MS))) begin // RL7
						meas_state <= MEAS_SAMPLE;
						meas_cnt <= '0;
					end else if (tick) begin
						meas_cnt <= meas_cnt + 1'b1;
					end
				end
				MEAS_SAMPLE: begin
					meas_state <= MEAS_WAIT;
					meas_cnt <= '0;
				end
				default: begin
					meas_state <= MEAS_WAIT;
					meas_cnt <= '0;
				end
			endcase
		end
	end

	// balancing sequencer, leaves off at once, other decisions only at a sample
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bal_state <= BAL_OFF;
		end else if (!auto_en) begin
			bal_state <= BAL_OFF;
		end else begin
			case (bal_state)
				BAL_OFF: bal_state <= (prequal_th == PREQ_DISABLED) ? BAL_QUAL : BAL_PREQ; // RL3
				BAL_PREQ: begin
					if (meas_state == MEAS_SAMPLE && sense.cell_diff >= {4'h0, prequal_th}) begin
						bal_state <= BAL_QUAL; // RL8
					end
				end
				BAL_QUAL: begin
					if (meas_state == MEAS_SAMPLE) begin
						if (sense.cell_diff >= {4'h0, start_th}) begin
							bal_state <= BAL_ACTIVE; // RL8
						end else if (prequal_th != PREQ_DISABLED && sense.cell_diff < {4'h0, prequal_th}) begin
							bal_state <= BAL_PREQ;
						end
					end
				end
				BAL_ACTIVE: begin
					if (meas_state == MEAS_SAMPLE &&
						({1'b0, sense.cell_diff} + {5'h0, exit_off, 1'b0}) < {5'h0, start_th}) begin
						bal_state <= BAL_QUAL; // RL8
					end
				end
				default: bal_state <= BAL_OFF;
			endcase
		end
	end

	// balancing outputs and status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_pause <= 1'b0;
			discharge_upper <= 1'b0;
			discharge_lower <= 1'b0;
			balance_active_status <= 1'b0;
			upper_cell_regulation_status <= 1'b0;
			lower_cell_regulation_status <= 1'b0;
		end else begin
			charge_pause <= pause_en && auto_en && (meas_state != MEAS_WAIT); // RL7
			discharge_upper <= bal_state == BAL_ACTIVE && meas_state == MEAS_WAIT && sense.upper_cell_higher;
			discharge_lower <= bal_state == BAL_ACTIVE && meas_state == MEAS_WAIT && !sense.upper_cell_higher;
			balance_active_status <= bal_state == BAL_ACTIVE || manual_balance_on; // RL1
			upper_cell_regulation_status <= sense.upper_cell_cv; // RL1
			lower_cell_regulation_status <= sense.lower_cell_cv; // RL1
		end
	end

	// zones and termination qualification
	assign zone_suspend = (sense.ts_warm && cfg.warm_voltage_select == ZONE_SUSPEND) ||
		(sense.ts_cool && cfg.cool_current_select == ZONE_SUSPEND); // RL17 RL18
	assign charging_allowed = sense.charge_enable && !sense.fault && sense.ts_in_range && // RL16
		!zone_suspend && !timer_fault_status;
	assign term_allowed = cfg.term_enable && !sense.in_ireg && !sense.in_vreg && !sense.in_treg && // RL11
		!sense.ts_warm && !sense.ts_cool; // RL19
	assign term_event = charging_allowed && !term_done && term_allowed && sense.above_rechg && sense.below_term &&
		(charge_phase == PH_FAST || charge_phase == PH_TAPER); // RL9

	// edges that reset the timers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_en_prev <= 1'b0;
			vbat_low_prev <= 1'b0;
			term_done_prev <= 1'b0;
		end else begin
			charge_en_prev <= sense.charge_enable;
			vbat_low_prev <= sense.vbat_low;
			term_done_prev <= term_done;
		end
	end
	assign en_rise = sense.charge_enable && !charge_en_prev;
	assign recharge = term_done && !sense.above_rechg;
	assign lowv_change = sense.vbat_low != vbat_low_prev;
	assign timer_clear = en_rise || recharge || lowv_change; // RL22 RL23

	// termination and top-off state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			term_done <= 1'b0;
		end else if (term_event) begin
			term_done <= 1'b1;
		end else if (!sense.charge_enable || recharge) begin
			term_done <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			topoff_len <= '0;
		end else if (reg_reset) begin
			topoff_len <= '0; // RL13
		end else if (term_event) begin
			topoff_len <= TIMER_W'(cfg.topoff_minutes) * HALF_PER_MIN; // RL14
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			topoff_active <= 1'b0;
		end else if (term_event && cfg.topoff_minutes != 8'h00 && !reg_reset) begin
			topoff_active <= 1'b1; // RL12
		end else if (topoff_exp || reg_reset || !sense.charge_enable || recharge) begin
			topoff_active <= 1'b0;
		end
	end

	// timers
	assign in_charge = sense.charge_enable && !term_done;
	assign timer_suspend = sense.fault || sense.supplement || !sense.ts_in_range || zone_suspend; // RL22
	assign half = cfg.half_rate_enable && (sense.in_ireg || sense.in_vreg || sense.in_treg ||
		bal_state == BAL_ACTIVE); // RL21
	assign safety_limit = TIMER_W'(cfg.safety_timer_duration) * HALF_PER_HOUR; // RL20

	half_rate_timer u_fast_timer (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick),
		.clear(timer_clear),
		.run(in_charge && !timer_suspend && cfg.timer_enable && !sense.vbat_low && !timer_fault_status), // RL20
		.half(half),
		.limit(safety_limit),
		.expired(fast_exp)
	);

	half_rate_timer u_pre_timer (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick),
		.clear(timer_clear),
		.run(in_charge && !timer_suspend && cfg.timer_enable && sense.vbat_low && !timer_fault_status), // RL23
		.half(half),
		.limit(PRE_LIMIT),
		.expired(pre_exp)
	);

	half_rate_timer u_topoff_timer (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick),
		.clear(en_rise || (term_done && !term_done_prev) || reg_reset), // RL13
		.run(topoff_active && !timer_suspend), // RL12
		.half(half),
		.limit(topoff_len),
		.expired(topoff_exp)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_fault_status <= 1'b0;
		end else if (fast_exp || pre_exp) begin
			timer_fault_status <= 1'b1; // RL20
		end else if (en_rise) begin
			timer_fault_status <= 1'b0;
		end
	end

	// charge phase
	always_comb begin
		if (!sense.charge_enable) begin
			next_phase = PH_IDLE;
		end else if (term_done) begin
			next_phase = topoff_active ? PH_TOPOFF : PH_DONE; // RL10 RL12
		end else if (!charging_allowed) begin
			next_phase = PH_IDLE;
		end else if (sense.vbat_short) begin
			next_phase = PH_TRICKLE;
		end else if (sense.vbat_low) begin
			next_phase = PH_PRE;
		end else if (sense.cv_mode) begin
			next_phase = PH_TAPER;
		end else begin
			next_phase = PH_FAST; // RL24
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_phase <= PH_IDLE;
			stat_oe <= 1'b0;
		end else begin
			charge_phase <= next_phase;
			stat_oe <= next_phase >= PH_TRICKLE && next_phase <= PH_TAPER; // RL10
		end
	end

	// zone limits and charge enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= '0;
		end else begin
			ctl.charge_run <= charging_allowed && !charge_pause && (!term_done || topoff_active); // RL16
			ctl.voltage_sel <= sense.ts_warm ? cfg.warm_voltage_select : 2'h0; // RL17
			ctl.current_pct <= sense.ts_warm ? (cfg.warm_current_select ? PCT_40 : PCT_100) :
				sense.ts_cool ? cfg.cool_current_select : PCT_100; // RL18
		end
	end

	// interrupt pulse
	assign fire = (next_phase != charge_phase && !cfg.charge_irq_mask) || // RL15
		((fast_exp || pre_exp) && !timer_fault_status); // RL20

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_n <= 1'b1;
			int_cnt <= 16'h0;
		end else if (fire) begin
			int_n <= 1'b0;
			int_cnt <= INT_LOAD; // RL25
		end else if (!int_n) begin
			if (int_cnt == 16'h0) begin
				int_n <= 1'b1;
			end else begin
				int_cnt <= int_cnt - 16'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_run <= 16'h0;
		end else if (fire) begin
			low_run <= 16'h1;
		end else if (!int_n && int_cnt != 16'h0) begin
			low_run <= low_run + 16'h1;
		end
	end

	property p_int_len;
		@(posedge clk) disable iff (!rst_n)
		$rose(int_n) |-> low_run == 16'(INT_PULSE_CYCLES);
	endproperty
	a_int_len: assert property (p_int_len) else $error("interrupt pulse length wrong"); // RL25

	property p_mask;
		@(posedge clk) disable iff (!rst_n)
		cfg.charge_irq_mask && int_n && !fast_exp && !pre_exp |=> int_n;
	endproperty
	a_mask: assert property (p_mask) else $error("masked charge pulse sent"); // RL15

	property p_term_done;
		@(posedge clk) disable iff (!rst_n)
		term_event && cfg.topoff_minutes == 8'h00 && !reg_reset ##1 sense.charge_enable && !recharge
			|=> charge_phase == PH_DONE && !stat_oe;
	endproperty
	a_term_done: assert property (p_term_done) else $error("termination phase wrong"); // RL10

	property p_topoff;
		@(posedge clk) disable iff (!rst_n)
		term_event && cfg.topoff_minutes != 8'h00 && !reg_reset ##1 sense.charge_enable && !recharge
			&& !topoff_exp |=> charge_phase == PH_TOPOFF;
	endproperty
	a_topoff: assert property (p_topoff) else $error("top-off phase missing"); // RL12

	property p_reg_hold;
		@(posedge clk) disable iff (!rst_n)
		sense.in_ireg || sense.in_vreg || sense.in_treg || !cfg.term_enable |-> !term_event;
	endproperty
	a_reg_hold: assert property (p_reg_hold) else $error("termination in regulation"); // RL11

	property p_zone_term;
		@(posedge clk) disable iff (!rst_n)
		sense.ts_warm || sense.ts_cool |-> !term_event;
	endproperty
	a_zone_term: assert property (p_zone_term) else $error("termination in warm or cool zone"); // RL19

	property p_ts_suspend;
		@(posedge clk) disable iff (!rst_n)
		!sense.ts_in_range |=> !ctl.charge_run;
	endproperty
	a_ts_suspend: assert property (p_ts_suspend) else $error("charging outside thermistor range"); // RL16

	property p_timer_fault;
		@(posedge clk) disable iff (!rst_n)
		(fast_exp || pre_exp) && !timer_fault_status |=> timer_fault_status && !int_n;
	endproperty
	a_timer_fault: assert property (p_timer_fault) else $error("timer fault not raised"); // RL20

	property p_bal_status;
		@(posedge clk) disable iff (!rst_n)
		bal_state == BAL_ACTIVE |=> balance_active_status;
	endproperty
	a_bal_status: assert property (p_bal_status) else $error("balance status not set"); // RL1
endmodule : charge_cycle_supervisor

// ===== design/half_rate_timer.sv
// charge timer counting half-milliseconds, half rate on request
`timescale 1ns/1ps
module half_rate_timer import charge_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic tick,
	input wire logic clear,
	input wire logic run,
	input wire logic half,
	input wire logic [TIMER_W-1:0] limit,
	// status
	output logic expired
);
	localparam logic [TIMER_W-1:0] STEP_FULL = TIMER_W'(2);
	localparam logic [TIMER_W-1:0] STEP_HALF = TIMER_W'(1);
	logic [TIMER_W-1:0] count;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (run && tick && !expired) begin
			count <= count + (half ? STEP_HALF : STEP_FULL);
		end
	end

	assign expired = (limit != '0) && (count >= limit);

	property p_half_step;
		@(posedge clk) disable iff (!rst_n)
		run && tick && half && !clear && !expired |=> count == $past(count) + STEP_HALF;
	endproperty
	a_half_step: assert property (p_half_step) else $error("half-rate step wrong"); // RL21
endmodule : half_rate_timer

// ===== tb/sense_model.sv
// analogue side stand-in: battery, charge loop and thermistor status
`timescale 1ns/1ps
module sense_model import charge_pkg::*; (
	// clock
	input wire logic clk,
	// scenario: 0 disabled, 1 fast charge, 2 full battery at low current, 3 warm zone in current regulation
	input wire logic [1:0] mode,
	// status towards the device
	output charge_sense_s sense
);
	always_ff @(posedge clk) begin
		sense <= '0;
		sense.ts_in_range <= 1'b1;
		sense.charge_enable <= (mode != 2'h0);
		sense.above_rechg <= (mode == 2'h2);
		sense.below_term <= (mode == 2'h2);
		sense.cv_mode <= (mode == 2'h2);
		sense.ts_warm <= (mode == 2'h3);
		sense.in_ireg <= (mode == 2'h3);
		sense.upper_cell_cv <= (mode == 2'h3);
	end
endmodule : sense_model

// ===== tb/testbench.sv
// self-checking bench for the charge-cycle supervisor
`timescale 1ns/1ps
module testbench import charge_pkg::*;;
	typedef struct packed {logic [7:0] a; logic we; logic [7:0] d; logic [7:0] q;} row_s;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_we = 1'b0;
	logic reg_reset = 1'b0;
	logic [7:0] reg_rdata;
	zone_cfg_s cfg = '0;
	charge_sense_s sense_raw;
	charge_ctl_s ctl;
	logic [2:0] charge_phase;
	logic stat_oe;
	logic int_n;
	logic manual_balance_on = 1'b0;
	logic charge_pause, discharge_upper, discharge_lower, timer_fault_status, balance_active_status;
	logic upper_cell_regulation_status, lower_cell_regulation_status;
	logic [1:0] mode = 2'h0;
	int err_count = 0;
	int checked = 0;
	int n;
	row_s rows [8] = '{'{8'h28, 1'b0, 8'h00, 8'h2a}, '{8'h29, 1'b0, 8'h00, 8'hf4}, '{8'h2a, 1'b0, 8'h00, 8'hc0},
		'{8'h30, 1'b0, 8'h00, 8'h00}, '{8'h29, 1'b1, 8'h33, 8'h33}, '{8'h2a, 1'b1, 8'hff, 8'hc0},
		'{8'h30, 1'b1, 8'h55, 8'h00}, '{8'h28, 1'b1, 8'h55, 8'h55}};

	always #2 clk = ~clk;

	sense_model partner (.clk(clk), .mode(mode), .sense(sense_raw));

	charge_cycle_supervisor #(.TICK_CYCLES(4), .INT_PULSE_CYCLES(8)) uut (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_reset(reg_reset), .reg_rdata(reg_rdata),
		.cfg(cfg), .manual_balance_on(manual_balance_on), .sense_raw(sense_raw), .ctl(ctl),
		.charge_pause(charge_pause), .discharge_upper(discharge_upper), .discharge_lower(discharge_lower),
		.charge_phase(charge_phase), .timer_fault_status(timer_fault_status),
		.balance_active_status(balance_active_status),
		.upper_cell_regulation_status(upper_cell_regulation_status),
		.lower_cell_regulation_status(lower_cell_regulation_status),
		.stat_oe(stat_oe), .int_n(int_n));

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic reg_op(input logic [7:0] a, input logic we, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_we <= we;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
		@(posedge clk);
		#1;
	endtask : reg_op

	// wait for a phase, then measure the interrupt pulse
	task automatic phase_pulse(input phase_t p, input int len);
		n = 0;
		while (charge_phase !== p && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("phase", {5'h00, charge_phase}, {5'h00, p});
		n = 0;
		while (int_n === 1'b0 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		check("pulse", n[7:0], len[7:0]);
	endtask : phase_pulse

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	initial begin
		#20000;
		err_count++;
		test_done;
	end

	initial begin
		cfg.term_enable <= 1'b1;
		cfg.timer_enable <= 1'b1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			reg_op(rows[i].a, rows[i].we, rows[i].d);
			check("rdata", reg_rdata, rows[i].q);
		end
		@(posedge clk);
		reg_reset <= 1'b1;
		@(posedge clk);
		reg_reset <= 1'b0;
		reg_op(8'h29, 1'b0, 8'h00);
		check("reset 29", reg_rdata, RST_BAL_THRESH);
		reg_op(8'h28, 1'b0, 8'h00);
		check("reset 28", reg_rdata, RST_BAL_TIMING);
		mode <= 2'h1;
		phase_pulse(PH_FAST, 8);
		check("run", {7'h00, ctl.charge_run}, 8'h01);
		check("stat low", {7'h00, stat_oe}, 8'h01);
		mode <= 2'h2;
		phase_pulse(PH_DONE, 8);
		check("stat high", {7'h00, stat_oe}, 8'h00);
		cfg.charge_irq_mask <= 1'b1;
		mode <= 2'h0;
		phase_pulse(PH_IDLE, 0);
		// warm zone, current regulation, manual balancing
		@(posedge clk);
		cfg.warm_voltage_select <= 2'h1;
		cfg.warm_current_select <= 1'b1;
		cfg.half_rate_enable <= 1'b1;
		manual_balance_on <= 1'b1;
		mode <= 2'h3;
		repeat (6) @(posedge clk);
		#1;
		check("warm phase", {5'h00, charge_phase}, {5'h00, PH_FAST});
		check("warm volt", {6'h00, ctl.voltage_sel}, 8'h01);
		check("warm cur", {6'h00, ctl.current_pct}, {6'h00, PCT_40});
		check("cell status", {5'h00, balance_active_status, upper_cell_regulation_status,
			lower_cell_regulation_status}, 8'h06);
		check("timer fault", {7'h00, timer_fault_status}, 8'h00);
		check("masked int", {7'h00, int_n}, 8'h01);
		cfg.warm_voltage_select <= ZONE_SUSPEND;
		repeat (3) @(posedge clk);
		#1;
		check("suspend phase", {5'h00, charge_phase}, {5'h00, PH_IDLE});
		check("suspend run", {7'h00, ctl.charge_run}, 8'h00);
		// reset in mid-run
		cfg.warm_voltage_select <= 2'h2;
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		#1;
		check("reset outs", {charge_pause, discharge_upper, discharge_lower, timer_fault_status,
			balance_active_status, stat_oe, int_n, reg_rdata[0]}, 8'h02);
		check("reset phase", {5'h00, charge_phase}, {5'h00, PH_IDLE});
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		check("recover", {5'h00, charge_phase}, {5'h00, PH_FAST});
		check("warm volt 2", {6'h00, ctl.voltage_sel}, 8'h02);
		check("recover cell", {7'h00, balance_active_status}, 8'h01);
		reg_op(8'h2a, 1'b0, 8'h00);
		check("reset 2a", reg_rdata, RST_BAL_CTRL);
		test_done;
	end
endmodule : testbench
